// ===== verification/dme_core_sva.sv
// Port assertions for the data movement executer
`timescale 1ns/1ps
module dme_core_sva (
  input wire logic mclk_i, // Clock
  input wire logic reset_n_i, // Reset
  input wire logic ce_i, // Enable
  input wire logic cmd_valid_i, // Offer
  input wire dme_pkg::dme_cmd_type cmd_i, // Command
  input wire logic cmd_ready_o, // Ready
  input wire logic [31:0] rf_rd_data_i, // Reg data
  input wire logic [31:0] sp_i, // Stack
  input wire logic sp_wr_en_o, // Stack write
  input wire dme_pkg::dme_fp_wr_type fp_wr_o, // Float write
  input wire logic mem_valid_o, // Request
  input wire dme_pkg::dme_mem_type mem_o, // Access
  input wire logic mem_ack_i, // Ack
  input wire logic done_o, // Done
  input wire logic illegal_o // Refused
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire take = cmd_valid_i && cmd_ready_o && ce_i;
  property p_push;
    take && cmd_i.op == dme_pkg::DME_OP_PUSH_ADDR |=> ##1 mem_valid_o && mem_o.we &&
      mem_o.addr == $past(sp_i, 2) - 32'h4 && mem_o.wdata[31:0] == $past(cmd_i.ea, 2);
  endproperty
  a_push: assert property (p_push) else $error("push write wrong");
  property p_build;
    take && cmd_i.op == dme_pkg::DME_OP_FRAME_BUILD |=> ##1 mem_valid_o && mem_o.we &&
      mem_o.addr == $past(sp_i, 2) - 32'h4 && mem_o.wdata[31:0] == $past(rf_rd_data_i);
  endproperty
  a_build: assert property (p_build) else $error("frame push wrong");
  property p_tear;
    take && cmd_i.op == dme_pkg::DME_OP_FRAME_TEARDOWN |=> ##1 mem_valid_o && !mem_o.we &&
      mem_o.addr == $past(rf_rd_data_i);
  endproperty
  a_tear: assert property (p_tear) else $error("frame pop wrong");
  property p_blk;
    take && cmd_i.op == dme_pkg::DME_OP_BLOCK16_MOVE |=> ##1 mem_valid_o && !mem_o.we &&
      mem_o.addr == ($past(cmd_i.src_addr, 2) & dme_pkg::DME_LINE_MASK);
  endproperty
  a_blk: assert property (p_blk) else $error("block read wrong");
  property p_rnd;
    take && cmd_i.op == dme_pkg::DME_OP_FP_MOVE_ROUND |-> ##2 fp_wr_o.en &&
      fp_wr_o.round == ($past(cmd_i.round_dbl, 2) ? dme_pkg::DME_RND_DOUBLE :
      dme_pkg::DME_RND_SINGLE);
  endproperty
  a_rnd: assert property (p_rnd) else $error("round move wrong");
  property p_ill;
    take && cmd_i.op == dme_pkg::DME_OP_FP_REG_LIST_MOVE && cmd_i.mask_from_dreg &&
      cmd_i.fp_ctrl_grp |=> done_o && illegal_o && !mem_valid_o;
  endproperty
  a_ill: assert property (p_ill) else $error("control list not refused");
  property p_sp;
    sp_wr_en_o |-> $past(mem_ack_i);
  endproperty
  a_sp: assert property (p_sp) else $error("stack update before access");
  property p_hold;
    mem_valid_o && !mem_ack_i |=> mem_valid_o && $stable(mem_o);
  endproperty
  a_hold: assert property (p_hold) else $error("access changed early");
  c_push: cover property (take && cmd_i.op == dme_pkg::DME_OP_PUSH_ADDR);
  c_ill: cover property (illegal_o);
  c_wr: cover property (mem_ack_i && mem_o.we);
endmodule : dme_core_sva

bind dme_core dme_core_sva u_dme_core_sva (.mclk_i, .reset_n_i, .ce_i, .cmd_valid_i, .cmd_i,
  .cmd_ready_o, .rf_rd_data_i, .sp_i, .sp_wr_en_o, .fp_wr_o, .mem_valid_o, .mem_o,
  .mem_ack_i, .done_o, .illegal_o);

// ===== verification/dme_core_tb.sv
// Self-checking bench for the data movement executer
`timescale 1ns/1ps
module dme_core_tb;
  logic mclk_i, reset_n_i, ce_i, cmd_valid_i, mem_ack_i, ill;
  logic cmd_ready_o, sp_wr_en_o, fp_rd_ctrl_o, mem_valid_o, done_o, illegal_o;
  logic [31:0] rf_rd_data_i, sp_i, sp_wr_data_o;
  logic [127:0] mem_rdata_i;
  logic [79:0] fp_rd_data_i;
  logic [3:0] rf_rd_idx_o;
  logic [2:0] fp_rd_idx_o;
  dme_pkg::dme_cmd_type cmd_i;
  dme_pkg::dme_rf_wr_type rf_wr_o;
  dme_pkg::dme_fp_wr_type fp_wr_o;
  dme_pkg::dme_mem_type mem_o;
  logic [31:0] rf [16];
  logic [127:0] rdq [$];
  dme_pkg::dme_mem_type mq [$];
  dme_pkg::dme_rf_wr_type wq [$];
  dme_pkg::dme_fp_wr_type fq [$];
  logic [31:0] sq [$];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  assign rf_rd_data_i = rf[rf_rd_idx_o];
  assign fp_rd_data_i = {76'h0, fp_rd_ctrl_o, fp_rd_idx_o};
  dme_core u_dme_core (.mclk_i, .reset_n_i, .ce_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
    .rf_rd_idx_o, .rf_rd_data_i, .rf_wr_o, .sp_i, .sp_wr_en_o, .sp_wr_data_o, .fp_rd_idx_o,
    .fp_rd_ctrl_o, .fp_rd_data_i, .fp_wr_o, .mem_valid_o, .mem_o, .mem_ack_i, .mem_rdata_i,
    .done_o, .illegal_o);
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // ----
  // Memory responder and watchdog
  // ----
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    mem_ack_i <= 1'b0;
    if (mem_valid_o && !mem_ack_i) begin
      mem_ack_i <= 1'b1;
      mq.push_back(mem_o);
      mem_rdata_i <= (rdq.size() > 0) ? rdq.pop_front() : 128'h0;
    end
    if (cyc == 2000) begin
      n_fail++;
      end_sim();
    end
  end
  task chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task run(input dme_pkg::dme_cmd_type c);
    mq.delete(); wq.delete(); fq.delete(); sq.delete();
    @(posedge mclk_i);
    cmd_i <= c;
    cmd_valid_i <= 1'b1;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    if (c.op == dme_pkg::DME_OP_ALT_BYTE_MOVE && !c.to_mem) begin
      ce_i <= 1'b0; // Freeze before any access is pending
      repeat (3) @(posedge mclk_i);
      ce_i <= 1'b1;
    end
    forever begin
      @(negedge mclk_i);
      if (rf_wr_o.en === 1'b1) wq.push_back(rf_wr_o);
      if (sp_wr_en_o === 1'b1) sq.push_back(sp_wr_data_o);
      if (fp_wr_o.en === 1'b1) fq.push_back(fp_wr_o);
      if (done_o === 1'b1) break;
    end
    ill = illegal_o;
  endtask : run
  task t_stack;
    dme_pkg::dme_cmd_type c;
    c = '0; c.op = dme_pkg::DME_OP_PUSH_ADDR; c.ea = 32'h1234_5678; run(c);
    chk({mq[0].addr, mq[0].wdata[31:0]}, {32'h0000_0ffc, 32'h1234_5678});
    chk(sq[0], 32'h0000_0ffc);
    rf[10] = 32'h2000_0040;
    c = '0; c.op = dme_pkg::DME_OP_FRAME_BUILD; c.areg = 3'h2; c.disp = 32'hffff_fff8; run(c);
    chk({mq[0].addr, mq[0].wdata[31:0]}, {32'h0000_0ffc, 32'h2000_0040});
    chk({wq[0].idx, wq[0].data, sq[0]}, {4'ha, 32'h0000_0ffc, 32'h0000_0ff4});
    rf[11] = 32'h0000_3000;
    rdq.push_back(128'hcafe_f00d);
    c = '0; c.op = dme_pkg::DME_OP_FRAME_TEARDOWN; c.areg = 3'h3; run(c);
    chk({mq[0].we, mq[0].addr, sq[0]}, {1'b0, 32'h0000_3000, 32'h0000_3004});
    chk({wq[0].idx, wq[0].data}, {4'hb, 32'hcafe_f00d});
  endtask : t_stack
  task t_alt;
    dme_pkg::dme_cmd_type c;
    rf[3] = 32'h1122_3344; rf[5] = 32'haaaa_0000; rf[12] = 32'h0000_4000;
    c = '0; c.op = dme_pkg::DME_OP_ALT_BYTE_MOVE; c.long_sz = 1'b1; c.to_mem = 1'b1;
    c.dreg = 3'h3; c.areg = 3'h4; c.disp = 32'h0000_0010; run(c);
    chk(mq.size(), 4);
    for (int i = 0; i < 4; i++) begin
      chk({mq[i].addr, mq[i].wdata[7:0]}, {32'(32'h4010 + 2 * i), 8'(8'h11 * (i + 1))});
    end
    rdq.push_back(128'hbe); rdq.push_back(128'hef);
    c.long_sz = 1'b0; c.to_mem = 1'b0; c.dreg = 3'h5; c.disp = 32'h0; run(c);
    chk({mq[1].addr, mq[1].we}, {32'h0000_4002, 1'b0});
    chk({wq[0].idx, wq[0].data}, {4'h5, 32'haaaa_beef});
  endtask : t_alt
  task t_blk_list;
    dme_pkg::dme_cmd_type c;
    rdq.push_back(128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210);
    c = '0; c.op = dme_pkg::DME_OP_BLOCK16_MOVE; c.src_addr = 32'h5007; c.dst_addr = 32'h600f;
    run(c);
    chk({mq[0].addr, mq[1].addr, mq[1].we}, {32'h5000, 32'h6000, 1'b1});
    chk(mq[1].wdata, 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210);
    rdq.push_back(128'h8001); rdq.push_back(128'h7fff);
    c = '0; c.op = dme_pkg::DME_OP_REG_LIST_MOVE; c.list_mask = 16'h0201; c.ea = 32'h7000;
    run(c);
    chk({mq[1].addr, wq[0].idx, wq[0].data}, {32'h7002, 4'h0, 32'hffff_8001});
    chk({wq[1].idx, wq[1].data}, {4'h9, 32'h0000_7fff});
    rf[2] = 32'h0bad_f00d; rf[15] = 32'h1357_9bdf;
    c.to_mem = 1'b1; c.long_sz = 1'b1; c.list_mask = 16'h8004; c.ea = 32'h7100; run(c);
    chk({mq[0].addr, mq[0].wdata[31:0]}, {32'h7100, 32'h0bad_f00d});
    chk({mq[1].addr, mq[1].wdata[31:0]}, {32'h7104, 32'h1357_9bdf});
  endtask : t_blk_list
  task t_fp;
    dme_pkg::dme_cmd_type c;
    for (int d = 0; d < 2; d++) begin
      c = '0; c.op = dme_pkg::DME_OP_FP_MOVE_ROUND; c.fp_src = 3'h1; c.fp_dst = 3'h6;
      c.round_dbl = d[0]; run(c);
      chk({fq[0].idx, fq[0].round, fq[0].data}, {3'h6, 2'(d + 1), 80'h1});
    end
    c = '0; c.op = dme_pkg::DME_OP_FP_REG_LIST_MOVE; c.fp_ctrl_grp = 1'b1; c.to_mem = 1'b1;
    c.list_mask = 16'h0005; c.ea = 32'h8000; run(c);
    chk({mq[0].addr, mq[0].wdata[31:0], mq[1].addr, mq[1].wdata[31:0]},
      {32'h8000, 32'h8, 32'h8004, 32'ha});
    c.mask_from_dreg = 1'b1; run(c);
    chk({ill, mq.size() == 0}, 2'b11);
  endtask : t_fp
  task end_sim;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  initial begin
    reset_n_i = 1'b0; ce_i = 1'b1; cmd_valid_i = 1'b0; cmd_i = '0;
    mem_ack_i = 1'b0; mem_rdata_i = '0; sp_i = 32'h0000_1000;
    foreach (rf[i]) rf[i] = 32'h0;
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_stack();
    t_alt();
    t_blk_list();
    t_fp();
    end_sim();
  end
endmodule : dme_core_tb

// ===== verilog/dme_alt_byte.sv
// Byte lane picker and placer for alternate-byte peripheral moves
`timescale 1ns/1ps
module dme_alt_byte (
  input wire logic [31:0] word_i,   // Register value
  input wire logic [1:0] sel_i,     // 0 selects bits 31:24
  input wire logic [7:0] byte_i,    // Byte read from memory
  output logic [7:0] byte_o,        // Byte to write to memory
  output logic [31:0] word_o        // Register with byte_i placed
);

  logic [4:0] shift;

  assign shift = {~sel_i, 3'b000};
  assign byte_o = word_i[shift +: 8];

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_lane
      assign word_o[8*k +: 8] = (sel_i == 2'(3 - k)) ? byte_i : word_i[8*k +: 8];
    end
  endgenerate

endmodule : dme_alt_byte

// ===== verilog/dme_core.sv
// Sequencer that executes data movement instructions
`timescale 1ns/1ps
module dme_core (
  input wire logic mclk_i,                               // Core clock
  input wire logic reset_n_i,                            // Async reset, active low
  input wire logic ce_i,                                 // Clock enable
  input wire logic cmd_valid_i,                          // Command offered
  input wire dme_pkg::dme_cmd_type cmd_i,                // Decoded command
  output logic cmd_ready_o,                              // Command taken when valid
  output logic [3:0] rf_rd_idx_o,                        // Integer register read select
  input wire logic [31:0] rf_rd_data_i,                  // Integer register read data
  output dme_pkg::dme_rf_wr_type rf_wr_o,                // Integer register write
  input wire logic [31:0] sp_i,                          // Current stack_pointer
  output logic sp_wr_en_o,                               // Stack pointer write strobe
  output logic [31:0] sp_wr_data_o,                      // New stack pointer
  output logic [2:0] fp_rd_idx_o,                        // Float register read select
  output logic fp_rd_ctrl_o,                             // Read a control register
  input wire logic [dme_pkg::DME_FP_W-1:0] fp_rd_data_i, // Float register read data
  output dme_pkg::dme_fp_wr_type fp_wr_o,                // Float register write
  output logic mem_valid_o,                              // Memory access pending
  output dme_pkg::dme_mem_type mem_o,                    // Memory access
  input wire logic mem_ack_i,                            // Memory access done
  input wire logic [dme_pkg::DME_LINE_W-1:0] mem_rdata_i, // Memory read data
  output logic done_o,                                   // Instruction finished
  output logic illegal_o                                 // Instruction refused
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_FB_PUSH = 4'h1,
    S_TD_POP = 4'h2,
    S_PA_PUSH = 4'h3,
    S_AB_PREP = 4'h4,
    S_AB_XFER = 4'h5,
    S_B16_RD = 4'h6,
    S_B16_WR = 4'h7,
    S_FL_MASK = 4'h8,
    S_LIST = 4'h9,
    S_FP_COPY = 4'ha
  } dme_state_type;

  dme_state_type state_q, state_d;
  dme_pkg::dme_cmd_type cmd_q, cmd_d;
  dme_pkg::dme_mem_type mem_q, mem_d;
  dme_pkg::dme_rf_wr_type rfw_q, rfw_d;
  dme_pkg::dme_fp_wr_type fpw_q, fpw_d;
  logic [31:0] addr_q, addr_d;
  logic [31:0] acc_q, acc_d;
  logic [31:0] spw_q, spw_d;
  logic [15:0] mask_q, mask_d;
  logic [1:0] cnt_q, cnt_d;
  logic pend_q, pend_d;
  logic spe_q, spe_d;
  logic done_q, done_d;
  logic ill_q, ill_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic dme_pkg::dme_mem_type mk_req(input logic we,
                                                  input dme_pkg::dme_size_type size,
                                                  input logic [31:0] addr,
                                                  input logic [dme_pkg::DME_LINE_W-1:0] wdata);
    dme_pkg::dme_mem_type r;
    r.we = we;
    r.size = size;
    r.addr = addr;
    r.wdata = wdata;
    return r;
  endfunction : mk_req

  function automatic dme_pkg::dme_rf_wr_type mk_rfw(input logic [3:0] idx,
                                                    input logic [31:0] data);
    dme_pkg::dme_rf_wr_type w;
    w.en = 1'b1;
    w.idx = idx;
    w.data = data;
    return w;
  endfunction : mk_rfw

  // ----------------------------------------------------------------
  // Decoding and selection
  // ----------------------------------------------------------------
  wire acked = pend_q & mem_ack_i;
  wire is_fp_list = (cmd_q.op == dme_pkg::DME_OP_FP_REG_LIST_MOVE);
  wire scan_found;
  wire [3:0] scan_idx;
  wire [7:0] alt_tx;
  wire [31:0] alt_word;
  wire [31:0] alt_src = cmd_q.to_mem ? rf_rd_data_i : acc_q;
  wire [1:0] alt_first = cmd_q.long_sz ? dme_pkg::DME_ALT_LONG_FIRST
                                       : dme_pkg::DME_ALT_WORD_FIRST;
  wire [31:0] int_step = cmd_q.long_sz ? dme_pkg::DME_LONG_STEP : dme_pkg::DME_WORD_STEP;
  wire fp_data_grp = is_fp_list & ~cmd_q.fp_ctrl_grp;
  wire [31:0] list_step = fp_data_grp ? dme_pkg::DME_EXT_STEP
                        : is_fp_list ? dme_pkg::DME_LONG_STEP : int_step;
  wire dme_pkg::dme_size_type list_size = fp_data_grp ? dme_pkg::DME_SZ_EXT
                                        : (is_fp_list | cmd_q.long_sz) ? dme_pkg::DME_SZ_LONG
                                        : dme_pkg::DME_SZ_WORD;
  wire [31:0] int_ld = cmd_q.long_sz ? mem_rdata_i[31:0]
                                     : {{16{mem_rdata_i[15]}}, mem_rdata_i[15:0]};
  wire [31:0] int_st = cmd_q.long_sz ? rf_rd_data_i : {16'h0000, rf_rd_data_i[15:0]};
  wire [95:0] fp_ext = {fp_rd_data_i[79:64], 16'h0000, fp_rd_data_i[63:0]};
  wire [dme_pkg::DME_FP_W-1:0] fp_ld = {mem_rdata_i[95:80], mem_rdata_i[63:0]};
  wire [31:0] list_st = fp_data_grp ? 32'h0000_0000
                      : is_fp_list ? fp_rd_data_i[31:0] : int_st;
  wire [dme_pkg::DME_LINE_W-1:0] list_wdata = fp_data_grp ? {32'h0000_0000, fp_ext}
                                                          : {96'h0, list_st};

  dme_mask_scan #(
    .W(16)
  ) u_scan (
    .mask_i(mask_q),
    .found_o(scan_found),
    .idx_o(scan_idx)
  );

  dme_alt_byte u_alt (
    .word_i(alt_src),
    .sel_i(cnt_q),
    .byte_i(mem_rdata_i[7:0]),
    .byte_o(alt_tx),
    .word_o(alt_word)
  );

  always_comb begin
    rf_rd_idx_o = 4'h0;
    if (state_q == S_IDLE) begin
      rf_rd_idx_o = {1'b1, cmd_i.areg};
    end else if (state_q == S_FB_PUSH || state_q == S_TD_POP) begin
      rf_rd_idx_o = {1'b1, cmd_q.areg};
    end else if (state_q == S_LIST) begin
      rf_rd_idx_o = scan_idx;
    end else if (state_q == S_AB_PREP || state_q == S_AB_XFER || state_q == S_FL_MASK) begin
      rf_rd_idx_o = {1'b0, cmd_q.dreg};
    end
  end

  assign fp_rd_idx_o = (state_q == S_FP_COPY) ? cmd_q.fp_src : scan_idx[2:0];
  assign fp_rd_ctrl_o = (state_q == S_LIST) & is_fp_list & cmd_q.fp_ctrl_grp;
  assign cmd_ready_o = (state_q == S_IDLE);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    mem_d = mem_q;
    addr_d = addr_q;
    acc_d = acc_q;
    mask_d = mask_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    rfw_d = '0;
    fpw_d = '0;
    spe_d = 1'b0;
    spw_d = spw_q;
    done_d = 1'b0;
    ill_d = 1'b0;
    if (acked) begin
      pend_d = 1'b0;
    end
    case (state_q)
      S_IDLE: begin
        if (cmd_valid_i) begin
          cmd_d = cmd_i;
          addr_d = cmd_i.ea;
          mask_d = cmd_i.list_mask;
          case (cmd_i.op)
            dme_pkg::DME_OP_FRAME_BUILD: begin
              state_d = S_FB_PUSH;
            end
            dme_pkg::DME_OP_FRAME_TEARDOWN: begin
              state_d = S_TD_POP;
            end
            dme_pkg::DME_OP_PUSH_ADDR: begin
              state_d = S_PA_PUSH;
            end
            dme_pkg::DME_OP_ALT_BYTE_MOVE: begin
              addr_d = rf_rd_data_i + cmd_i.disp;
              cnt_d = cmd_i.long_sz ? dme_pkg::DME_ALT_LONG_FIRST
                                    : dme_pkg::DME_ALT_WORD_FIRST;
              state_d = S_AB_PREP;
            end
            dme_pkg::DME_OP_BLOCK16_MOVE: begin
              addr_d = cmd_i.src_addr & dme_pkg::DME_LINE_MASK;
              state_d = S_B16_RD;
            end
            dme_pkg::DME_OP_REG_LIST_MOVE: begin
              state_d = S_LIST;
            end
            dme_pkg::DME_OP_FP_REG_LIST_MOVE: begin
              if (cmd_i.mask_from_dreg && cmd_i.fp_ctrl_grp) begin
                ill_d = 1'b1;
                done_d = 1'b1;
              end else if (cmd_i.mask_from_dreg) begin
                state_d = S_FL_MASK;
              end else begin
                mask_d = cmd_i.fp_ctrl_grp ? {13'h0000, cmd_i.list_mask[2:0] &
                                             dme_pkg::DME_FP_CTRL_MASK}
                                           : {8'h00, cmd_i.list_mask[7:0] &
                                             dme_pkg::DME_FP_DATA_MASK};
                state_d = S_LIST;
              end
            end
            dme_pkg::DME_OP_FP_MOVE_ROUND: begin
              state_d = S_FP_COPY;
            end
            default: begin
              ill_d = 1'b1;
              done_d = 1'b1;
            end
          endcase
        end
      end
      S_FB_PUSH: begin
        if (!pend_q) begin
          addr_d = sp_i - dme_pkg::DME_SP_STEP;
          mem_d = mk_req(1'b1, dme_pkg::DME_SZ_LONG, sp_i - dme_pkg::DME_SP_STEP,
                         {96'h0, rf_rd_data_i});
          pend_d = 1'b1;
        end else if (acked) begin
          rfw_d = mk_rfw({1'b1, cmd_q.areg}, addr_q);
          spe_d = 1'b1;
          spw_d = addr_q + cmd_q.disp;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_TD_POP: begin
        if (!pend_q) begin
          addr_d = rf_rd_data_i;
          mem_d = mk_req(1'b0, dme_pkg::DME_SZ_LONG, rf_rd_data_i, '0);
          pend_d = 1'b1;
        end else if (acked) begin
          rfw_d = mk_rfw({1'b1, cmd_q.areg}, mem_rdata_i[31:0]);
          spe_d = 1'b1;
          spw_d = addr_q + dme_pkg::DME_SP_STEP;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_PA_PUSH: begin
        if (!pend_q) begin
          addr_d = sp_i - dme_pkg::DME_SP_STEP;
          mem_d = mk_req(1'b1, dme_pkg::DME_SZ_LONG, sp_i - dme_pkg::DME_SP_STEP,
                         {96'h0, cmd_q.ea});
          pend_d = 1'b1;
        end else if (acked) begin
          spe_d = 1'b1;
          spw_d = addr_q;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_AB_PREP: begin
        acc_d = rf_rd_data_i;
        state_d = S_AB_XFER;
      end
      S_AB_XFER: begin
        if (!pend_q) begin
          mem_d = mk_req(cmd_q.to_mem, dme_pkg::DME_SZ_BYTE, addr_q,
                         {120'h0, alt_tx});
          pend_d = 1'b1;
        end else if (acked) begin
          if (!cmd_q.to_mem) begin
            acc_d = alt_word;
          end
          addr_d = addr_q + dme_pkg::DME_ALT_STEP;
          cnt_d = cnt_q + 2'h1;
          if (cnt_q == dme_pkg::DME_ALT_LAST) begin
            if (!cmd_q.to_mem) begin
              rfw_d = mk_rfw({1'b0, cmd_q.dreg}, alt_word);
            end
            done_d = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      S_B16_RD: begin
        if (!pend_q) begin
          mem_d = mk_req(1'b0, dme_pkg::DME_SZ_LINE, addr_q, '0);
          pend_d = 1'b1;
        end else if (acked) begin
          addr_d = cmd_q.dst_addr & dme_pkg::DME_LINE_MASK;
          mem_d.wdata = mem_rdata_i;
          state_d = S_B16_WR;
        end
      end
      S_B16_WR: begin
        if (!pend_q) begin
          mem_d = mk_req(1'b1, dme_pkg::DME_SZ_LINE, addr_q, mem_q.wdata);
          pend_d = 1'b1;
        end else if (acked) begin
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_FL_MASK: begin
        mask_d = {8'h00, rf_rd_data_i[7:0] & dme_pkg::DME_FP_DATA_MASK};
        state_d = S_LIST;
      end
      S_LIST: begin
        if (!pend_q && !scan_found) begin
          done_d = 1'b1;
          state_d = S_IDLE;
        end else if (!pend_q) begin
          mem_d = mk_req(cmd_q.to_mem, list_size, addr_q, list_wdata);
          pend_d = 1'b1;
        end else if (acked) begin
          if (!cmd_q.to_mem && is_fp_list) begin
            fpw_d.en = 1'b1;
            fpw_d.ctrl = cmd_q.fp_ctrl_grp;
            fpw_d.idx = scan_idx[2:0];
            fpw_d.data = fp_data_grp ? fp_ld
                                     : {48'h0, mem_rdata_i[31:0]};
          end else if (!cmd_q.to_mem) begin
            rfw_d = mk_rfw(scan_idx, int_ld);
          end
          mask_d = mask_q & ~(16'h0001 << scan_idx);
          addr_d = addr_q + list_step;
        end
      end
      S_FP_COPY: begin
        fpw_d.en = 1'b1;
        fpw_d.idx = cmd_q.fp_dst;
        fpw_d.data = fp_rd_data_i;
        fpw_d.round = cmd_q.round_dbl ? dme_pkg::DME_RND_DOUBLE
                                      : dme_pkg::DME_RND_SINGLE;
        done_d = 1'b1;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= S_IDLE;
      cmd_q <= '0;
      mem_q <= '0;
      rfw_q <= '0;
      fpw_q <= '0;
      addr_q <= dme_pkg::DME_ADDR_RST;
      acc_q <= dme_pkg::DME_ADDR_RST;
      spw_q <= dme_pkg::DME_ADDR_RST;
      mask_q <= dme_pkg::DME_MASK_RST;
      cnt_q <= dme_pkg::DME_ALT_LONG_FIRST;
      pend_q <= 1'b0;
      spe_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      mem_q <= mem_d;
      rfw_q <= rfw_d;
      fpw_q <= fpw_d;
      addr_q <= addr_d;
      acc_q <= acc_d;
      spw_q <= spw_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      spe_q <= spe_d;
      done_q <= done_d;
      ill_q <= ill_d;
    end
  end

  assign rf_wr_o = rfw_q;
  assign fp_wr_o = fpw_q;
  assign sp_wr_en_o = spe_q;
  assign sp_wr_data_o = spw_q;
  assign mem_valid_o = pend_q;
  assign mem_o = mem_q;
  assign done_o = done_q;
  assign illegal_o = ill_q;

endmodule : dme_core

// ===== verilog/dme_mask_scan.sv
// Lowest-set-bit finder for register list masks
`timescale 1ns/1ps
module dme_mask_scan #(
  parameter int W = 16
) (
  input wire logic [W-1:0] mask_i,         // Register list mask
  output logic found_o,                    // Any bit set
  output logic [$clog2(W)-1:0] idx_o       // Lowest set bit
);

  logic [W:0] none_below;
  logic [W-1:0] pick;

  assign none_below[0] = 1'b1;

  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_bit
      assign pick[k] = mask_i[k] & none_below[k];
      assign none_below[k+1] = none_below[k] & ~mask_i[k];
    end
  endgenerate

  always_comb begin
    idx_o = '0;
    for (int j = 0; j < W; j++) begin
      if (pick[j]) begin
        idx_o = j[$clog2(W)-1:0];
      end
    end
  end

  assign found_o = ~none_below[W];

endmodule : dme_mask_scan

// ===== verilog/dme_pkg.sv
// Shared constants, enumerations and carriers for the data movement executer
package dme_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DME_FP_W = 80;
  localparam int DME_LINE_W = 128;

  // ----------------------------------------------------------------
  // Address steps and alignment
  // ----------------------------------------------------------------
  localparam logic [31:0] DME_SP_STEP = 32'h0000_0004;
  localparam logic [31:0] DME_ALT_STEP = 32'h0000_0002;
  localparam logic [31:0] DME_WORD_STEP = 32'h0000_0002;
  localparam logic [31:0] DME_LONG_STEP = 32'h0000_0004;
  localparam logic [31:0] DME_EXT_STEP = 32'h0000_000c;
  localparam logic [31:0] DME_LINE_MASK = 32'hffff_fff0;

  // ----------------------------------------------------------------
  // Byte lane counters of the alternate-byte move
  // ----------------------------------------------------------------
  localparam logic [1:0] DME_ALT_LONG_FIRST = 2'h0;
  localparam logic [1:0] DME_ALT_WORD_FIRST = 2'h2;
  localparam logic [1:0] DME_ALT_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and register list masks
  // ----------------------------------------------------------------
  localparam logic [31:0] DME_ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] DME_MASK_RST = 16'h0000;
  localparam logic [7:0] DME_FP_DATA_MASK = 8'hff;
  localparam logic [2:0] DME_FP_CTRL_MASK = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DME_OP_NONE = 4'h0,
    DME_OP_FRAME_BUILD = 4'h1,
    DME_OP_FRAME_TEARDOWN = 4'h2,
    DME_OP_PUSH_ADDR = 4'h3,
    DME_OP_ALT_BYTE_MOVE = 4'h4,
    DME_OP_BLOCK16_MOVE = 4'h5,
    DME_OP_REG_LIST_MOVE = 4'h6,
    DME_OP_FP_REG_LIST_MOVE = 4'h7,
    DME_OP_FP_MOVE_ROUND = 4'h8
  } dme_op_type;

  typedef enum logic [2:0] {
    DME_SZ_BYTE = 3'h0,
    DME_SZ_WORD = 3'h1,
    DME_SZ_LONG = 3'h2,
    DME_SZ_EXT = 3'h3,
    DME_SZ_LINE = 3'h4
  } dme_size_type;

  typedef enum logic [1:0] {
    DME_RND_NONE = 2'h0,
    DME_RND_SINGLE = 2'h1,
    DME_RND_DOUBLE = 2'h2
  } dme_round_type;

  typedef struct packed {
    dme_op_type op;
    logic long_sz;        // 1: long word, 0: word
    logic to_mem;         // 1: register to memory
    logic [2:0] areg;     // address_reg number
    logic [2:0] dreg;     // data_reg number
    logic [2:0] fp_src;
    logic [2:0] fp_dst;
    logic round_dbl;      // 1: double, 0: single
    logic fp_ctrl_grp;    // List names control registers
    logic mask_from_dreg; // List mask held in data_reg
    logic [15:0] list_mask;
    logic [31:0] disp;    // Sign-extended displacement
    logic [31:0] ea;      // Computed effective address
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
  } dme_cmd_type;

  typedef struct packed {
    logic we;
    dme_size_type size;
    logic [31:0] addr;
    logic [DME_LINE_W-1:0] wdata;
  } dme_mem_type;

  typedef struct packed {
    logic en;
    logic [3:0] idx;      // 0-7 data_reg, 8-15 address_reg
    logic [31:0] data;
  } dme_rf_wr_type;

  typedef struct packed {
    logic en;
    logic ctrl;           // 1: fp_control_reg/fp_status_reg/fp_instr_addr_reg
    logic [2:0] idx;
    logic [DME_FP_W-1:0] data;
    dme_round_type round;
  } dme_fp_wr_type;

endpackage : dme_pkg
